// >>> hw/dcp_defs.svh
// Constants of the dual wiper SPI control block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and each design module that uses it.
// What this block does
// - Wiper code 00h sits at the low terminal, 7Fh at the high, monotonic between.
// - Shutdown opens the high terminal and ties wiper terminal to low terminal.
// - Shutdown when the pin is low or the shutdown control bit is 0.
// - Interface and registers stay usable in shutdown; wiper setting is kept.
// - Read data leaves the open-drain output on falling serial clock edges.
// - Input bits are sampled on rising serial clock edges while selected.
// - Chip select must fall first; while high the output floats and idles.
// - Wipers start at 40h, then reload from their initial-value registers.
// - Address 0 reaches potentiometer 0, address 1 reaches potentiometer 1.
// - General purpose at 2 to 6, 7 reserved, access control at 8.
// - Volatile select 0 reaches initial values and wipers; 1 wipers only; resets 0.
// - Shutdown control bit resets to 1.
// - Write-in-progress flag reads 1 while a non-volatile write runs.
// - No write changes any register while the write-in-progress flag is 1.
// - Slave only, mode 0, host drives clock and chip select.
// - Every byte travels most significant bit first.
// - First byte is the identification byte; anything else is ignored.
// - Second byte holds instruction in bits 7:4 and address in 3:0.
// - Instruction 1011 reads, 1100 writes, all others invalid.
// - Further write bytes advance the pointer, wrapping from 6 to 0.
// - Non-volatile write starts at chip select rise, finishes within 20 ms.
// - Reads stream bytes from the pointer, advancing and wrapping from 6 to 0.
`ifndef DCP_DEFS_SVH
`define DCP_DEFS_SVH
`define ADDR_POT0       4'h0
`define ADDR_POT1       4'h1
`define ADDR_GP_LAST    4'h6
`define ADDR_ACR        4'h8
`define INSTR_READ      4'hb
`define INSTR_WRITE     4'hc
`define ACR_VOL_BIT     7
`define ACR_SHUTDOWN_CONTROL_BIT    6
`define ACR_WIP_BIT     5
`define WIPER_PWRUP     7'h40
`define VOL_RESET       1'b0
`define SHUTDOWN_CONTROL_RESET      1'b1
`define NV_CELL_INIT    8'h40
`define NV_DEPTH        7
`define NV_WRITE_TIME_US 20000
`define MCLK_MHZ        20
`define RECALL_DELAY_CYCLES 16
`endif

// >>> hw/dcp_pkg.sv
// Types shared by the dual wiper control block.
// Assumes dcp_defs.svh sits on the include path.
`include "dcp_defs.svh"
package dcp_pkg;
    typedef logic [6:0] wiper_t;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] nv_addr_t;
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_ID     = 6'b000010,
        ST_CMD    = 6'b000100,
        ST_WR     = 6'b001000,
        ST_RD     = 6'b010000,
        ST_IGNORE = 6'b100000
    } spi_state_t;
endpackage

// >>> hw/nv_mem_if.sv
// Port bundle between the control logic and the non-volatile store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface nv_mem_if;
    logic              we;
    dcp_pkg::nv_addr_t waddr;
    dcp_pkg::byte_t    wdata;
    dcp_pkg::nv_addr_t raddr;
    dcp_pkg::byte_t    rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> hw/sync_2ff.sv
// Two flip-flop synchroniser for pins from outside the mclk domain.
// Assumes each bit is an independent level.
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
    parameter int            WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            meta_q <= INIT;
            q      <= INIT;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> hw/nv_store.sv
// Non-volatile cell array: one write port, one registered read port.
// Assumes writes come only from the committed write cycle.
`timescale 1ns/1ns
`default_nettype none
`include "dcp_defs.svh"
module nv_store #(
    parameter int DEPTH = `NV_DEPTH
) (
    input wire logic clk,
    input wire logic nrst,
    nv_mem_if.mem    bus
);
    import dcp_pkg::*;
    byte_t cells [DEPTH];
    // Cells are loaded with 40h at reset only so a simulation starts defined
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
                cells[i] <= `NV_CELL_INIT;
        end
        else if (bus.we && (int'(bus.waddr) < DEPTH))
            cells[bus.waddr] <= bus.wdata;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
            bus.rdata <= 8'h00;
        else if (int'(bus.raddr) < DEPTH)
            bus.rdata <= cells[bus.raddr];
        else
            bus.rdata <= 8'h00;
    end
endmodule
`default_nettype wire

// >>> hw/dcp_spi_ctrl.sv
// Register and serial control of a dual digital potentiometer, mode 0 SPI slave.
// Assumes chip select, serial clock, data in and shutdown pin are asynchronous pins,
// sampled by mclk, with serial clock at most an eighth of mclk.
`timescale 1ns/1ns
`default_nettype none
`include "dcp_defs.svh"
module dcp_spi_ctrl #(
    // Identification pattern value is arbitrary
    parameter logic [3:0] ID_PATTERN      = 4'ha,
    parameter int         NV_WRITE_CYCLES = `NV_WRITE_TIME_US * `MCLK_MHZ,
    parameter int         RECALL_CYCLES   = `RECALL_DELAY_CYCLES
) (
    input  wire logic      mclk,
    input  wire logic      nrst,
    input  wire logic      csN,
    input  wire logic      sck,
    input  wire logic      sdi,
    input  wire logic      shutdownPinN,
    output var  dcp_pkg::wiper_t wiper0,
    output var  dcp_pkg::wiper_t wiper1,
    output var  logic      highTermOpen,
    output var  logic      wiperToLow,
    output var  logic      sdoOut,
    output var  logic      sdoOeN,
    output var  logic      nvWriteBusy
);
    import dcp_pkg::*;

    localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);
    localparam int RCW = $clog2(RECALL_CYCLES + 1);
    localparam logic [2:0] RC_WAIT  = 3'h0;
    localparam logic [2:0] RC_READ0 = 3'h1;
    localparam logic [2:0] RC_LOAD0 = 3'h2;
    localparam logic [2:0] RC_LOAD1 = 3'h3;
    localparam logic [2:0] RC_DONE  = 3'h4;

    logic [3:0]     pinS;
    logic           csS;
    logic           sckS;
    logic           sdiS;
    logic           shdnPinS;
    logic           csPrev_q;
    logic           sckPrev_q;
    logic           sckRise;
    logic           sckFall;
    logic           csFall;
    logic           csRise;
    logic           selected;
    logic [2:0]     bitCnt_q;
    logic [6:0]     rxShift_q;
    byte_t          byteIn;
    logic           byteDone;
    spi_state_t     state_q;
    logic [3:0]     ptr_q;
    byte_t          txShift_q;
    logic           loadTx_q;
    logic           txActive_q;
    logic           readStep;
    logic           wrStrobe;
    wiper_t         wiper0_q;
    wiper_t         wiper1_q;
    logic           vol_q;
    logic           shdnBit_q;
    logic           wip_q;
    logic [NVW-1:0] nvTimer_q;
    logic           nvCommit;
    logic           nvPend_q;
    nv_addr_t       nvAddr_q;
    byte_t          nvData_q;
    logic           nvTarget;
    logic [RCW-1:0] recallCnt_q;
    logic [2:0]     recallStep_q;
    logic           recallBusy;
    byte_t          rdValue;
    byte_t          acrValue;

    nv_mem_if nvBus ();

    nv_store #(
        .DEPTH (`NV_DEPTH)
    ) nvCells (
        .clk  (mclk),
        .nrst (nrst),
        .bus  (nvBus)
    );

    // Chip select idles high so no false select edge appears at reset release
    sync_2ff #(
        .WIDTH (4),
        .INIT  (4'b1001)
    ) pinSync (
        .clk  (mclk),
        .nrst (nrst),
        .d    ({csN, sck, sdi, shutdownPinN}),
        .q    (pinS)
    );

    assign csS      = pinS[3];
    assign sckS     = pinS[2];
    assign sdiS     = pinS[1];
    assign shdnPinS = pinS[0];

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            csPrev_q  <= 1'b1;
            sckPrev_q <= 1'b0;
        end
        else
        begin
            csPrev_q  <= csS;
            sckPrev_q <= sckS;
        end
    end

    assign selected = ~csS;
    assign csFall   = csPrev_q & ~csS;
    assign csRise   = ~csPrev_q & csS;
    assign sckRise  = sckS & ~sckPrev_q;
    assign sckFall  = ~sckS & sckPrev_q;

    // Serial input shift, sampled on rising serial clock, first bit is the MSB
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            bitCnt_q  <= 3'h0;
            rxShift_q <= 7'h00;
        end
        else if (csFall)
            bitCnt_q <= 3'h0;
        else if (selected && sckRise)
        begin
            bitCnt_q  <= bitCnt_q + 3'h1;
            rxShift_q <= {rxShift_q[5:0], sdiS};
        end
    end

    assign byteDone = selected & sckRise & (bitCnt_q == 3'h7);
    assign byteIn   = {rxShift_q, sdiS};

    // Transaction sequencing: identification, instruction, then data bytes
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            state_q <= ST_IDLE;
        else if (csFall)
            state_q <= ST_ID;
        else if (csS)
            state_q <= ST_IDLE;
        else if (byteDone)
        begin
            unique case (state_q)
                ST_ID:
                    state_q <= (byteIn == {ID_PATTERN, 4'h0}) ? ST_CMD : ST_IGNORE;
                ST_CMD:
                begin
                    if (byteIn[7:4] == `INSTR_READ)
                        state_q <= ST_RD;
                    else if (byteIn[7:4] == `INSTR_WRITE)
                        state_q <= ST_WR;
                    else
                        state_q <= ST_IGNORE;
                end
                ST_IDLE, ST_WR, ST_RD, ST_IGNORE:
                    state_q <= state_q;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
            ptr_q <= 4'h0;
        else if (byteDone && (state_q == ST_CMD))
            ptr_q <= byteIn[3:0];
        else if (byteDone && ((state_q == ST_WR) || (state_q == ST_RD)))
            ptr_q <= (ptr_q == `ADDR_GP_LAST) ? `ADDR_POT0 : ptr_q + 4'h1;
    end

    assign wrStrobe = byteDone & (state_q == ST_WR) & ~wip_q;
    assign nvTarget = (ptr_q <= `ADDR_GP_LAST) & ~((ptr_q <= `ADDR_POT1) & vol_q);

    // Recall of initial values into the wipers after reset
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            recallCnt_q  <= '0;
            recallStep_q <= RC_WAIT;
        end
        else if (recallStep_q == RC_WAIT)
        begin
            if (recallCnt_q == RCW'(RECALL_CYCLES - 1))
                recallStep_q <= RC_READ0;
            else
                recallCnt_q <= recallCnt_q + RCW'(1);
        end
        else if (recallBusy)
            recallStep_q <= recallStep_q + 3'h1;
    end

    assign recallBusy = (recallStep_q != RC_DONE);

    // Wiper registers; the held value survives shutdown untouched
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            wiper0_q <= `WIPER_PWRUP;
            wiper1_q <= `WIPER_PWRUP;
        end
        else if (recallStep_q == RC_LOAD0)
            wiper0_q <= nvBus.rdata[6:0];
        else if (recallStep_q == RC_LOAD1)
            wiper1_q <= nvBus.rdata[6:0];
        else if (wrStrobe && (ptr_q == `ADDR_POT0))
            wiper0_q <= byteIn[6:0];
        else if (wrStrobe && (ptr_q == `ADDR_POT1))
            wiper1_q <= byteIn[6:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            vol_q     <= `VOL_RESET;
            shdnBit_q <= `SHUTDOWN_CONTROL_RESET;
        end
        else if (wrStrobe && (ptr_q == `ADDR_ACR))
        begin
            vol_q     <= byteIn[`ACR_VOL_BIT];
            shdnBit_q <= byteIn[`ACR_SHUTDOWN_CONTROL_BIT];
        end
    end

    // Only the last non-volatile byte of a transaction is kept for the write cycle
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            nvPend_q <= 1'b0;
            nvAddr_q <= 3'h0;
            nvData_q <= 8'h00;
        end
        else if (nvCommit)
            nvPend_q <= 1'b0;
        else if (wrStrobe && nvTarget)
        begin
            nvPend_q <= 1'b1;
            nvAddr_q <= ptr_q[2:0];
            nvData_q <= byteIn;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            wip_q     <= 1'b0;
            nvTimer_q <= '0;
        end
        else if (wip_q)
        begin
            if (nvCommit)
            begin
                wip_q     <= 1'b0;
                nvTimer_q <= '0;
            end
            else
                nvTimer_q <= nvTimer_q + NVW'(1);
        end
        else if (csRise && nvPend_q)
            wip_q <= 1'b1;
    end

    assign nvCommit    = wip_q & (nvTimer_q == NVW'(NV_WRITE_CYCLES - 1));
    assign nvBus.we    = nvCommit;
    assign nvBus.waddr = nvAddr_q;
    assign nvBus.wdata = nvData_q;
    assign nvBus.raddr = recallBusy ? ((recallStep_q == RC_LOAD0) ? 3'h1 : 3'h0) : ptr_q[2:0];

    assign acrValue = {vol_q, shdnBit_q, wip_q, 5'h00};

    always_comb
    begin
        rdValue = 8'h00;
        if (ptr_q == `ADDR_POT0)
            rdValue = vol_q ? {1'b0, wiper0_q} : nvBus.rdata;
        else if (ptr_q == `ADDR_POT1)
            rdValue = vol_q ? {1'b0, wiper1_q} : nvBus.rdata;
        else if (ptr_q <= `ADDR_GP_LAST)
            rdValue = nvBus.rdata;
        else if (ptr_q == `ADDR_ACR)
            rdValue = acrValue;
    end

    // Read data is fetched a whole half period after the pointer moves
    assign readStep = byteDone & ((state_q == ST_RD) ||
                      ((state_q == ST_CMD) && (byteIn[7:4] == `INSTR_READ)));

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            txShift_q  <= 8'h00;
            loadTx_q   <= 1'b0;
            txActive_q <= 1'b0;
        end
        else if (csFall || csS)
        begin
            loadTx_q   <= 1'b0;
            txActive_q <= 1'b0;
        end
        else if (readStep)
            loadTx_q <= 1'b1;
        else if (sckFall && (state_q == ST_RD))
        begin
            if (loadTx_q)
            begin
                txShift_q  <= rdValue;
                loadTx_q   <= 1'b0;
                txActive_q <= 1'b1;
            end
            else
                txShift_q <= {txShift_q[6:0], 1'b0};
        end
    end

    // Pin is only ever pulled low; a one is the external pull-up
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            sdoOut <= 1'b0;
            sdoOeN <= 1'b1;
        end
        else
        begin
            sdoOut <= 1'b0;
            sdoOeN <= ~(selected & (state_q == ST_RD) & txActive_q & ~txShift_q[7]);
        end
    end

    // Pin and control bit combine so either one alone forces shutdown
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            highTermOpen <= 1'b0;
            wiperToLow   <= 1'b0;
        end
        else
        begin
            highTermOpen <= ~shdnPinS | ~shdnBit_q;
            wiperToLow   <= ~shdnPinS | ~shdnBit_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            wiper0      <= `WIPER_PWRUP;
            wiper1      <= `WIPER_PWRUP;
            nvWriteBusy <= 1'b0;
        end
        else
        begin
            wiper0      <= wiper0_q;
            wiper1      <= wiper1_q;
            nvWriteBusy <= wip_q;
        end
    end
endmodule
`default_nettype wire

// >>> tb/wiper_ctrl_monitor.sv
// Concurrent checks on the ports of the dual wiper control block.
// Assumes a bind to dcp_spi_ctrl that hands on its count parameters.
`timescale 1ns/1ns
`default_nettype none
module wiper_ctrl_monitor #(
    parameter int NV_WRITE_CYCLES = 400000,
    parameter int RECALL_CYCLES   = 16
) (
    input wire logic            mclk,
    input wire logic            nrst,
    input wire logic            csN,
    input wire logic            shutdownPinN,
    input wire dcp_pkg::wiper_t wiper0,
    input wire dcp_pkg::wiper_t wiper1,
    input wire logic            highTermOpen,
    input wire logic            wiperToLow,
    input wire logic            sdoOut,
    input wire logic            sdoOeN,
    input wire logic            nvWriteBusy
);
    import dcp_pkg::*;
    int busyRun_q;
    int sinceRst_q;
    always_ff @(posedge mclk)
    begin
        busyRun_q <= (!nrst || !nvWriteBusy) ? 0 : busyRun_q + 1;
    end
    // Recall after reset may move the wipers while deselected, so wait it out
    always_ff @(posedge mclk)
    begin
        sinceRst_q <= !nrst ? 0 : (sinceRst_q < 1000 ? sinceRst_q + 1 : sinceRst_q);
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence csIdle;
        csN [*6];
    endsequence
    sequence nvStart;
        $rose(nvWriteBusy);
    endsequence
    a_sdo_idle_released:
    assert property (csIdle |-> sdoOeN) else $error("sdo driven while deselected");
    a_sdo_open_drain:
    assert property (!sdoOeN |-> !sdoOut) else $error("sdo drives high");
    a_reset_wiper_mid:
    assert property (!$past(nrst) |-> wiper0 == 7'h40 && wiper1 == 7'h40 && sdoOeN
        && !nvWriteBusy) else $error("bad state after reset");
    a_wiper_idle_stable:
    assert property ((sinceRst_q > RECALL_CYCLES + 8) && csN && $past(csN)
        |-> $stable(wiper0) && $stable(wiper1)) else $error("wiper moved while idle");
    a_busy_locks_wipers:
    assert property (nvWriteBusy [*2] |-> $stable(wiper0) && $stable(wiper1))
        else $error("wiper written while busy");
    a_busy_run_bounded:
    assert property (busyRun_q <= NV_WRITE_CYCLES + 8) else $error("nv write too long");
    a_busy_after_select:
    assert property (nvStart |-> csN && $past(csN, 3)) else $error("nv write not at cs rise");
    a_pin_shutdown_fast:
    assert property ($fell(shutdownPinN) |-> ##[1:5] highTermOpen && wiperToLow)
        else $error("pin shutdown late");
    a_pin_shutdown_hold:
    assert property (!shutdownPinN [*6] |-> highTermOpen) else $error("shutdown lost");
    a_shutdown_pair:
    assert property (highTermOpen == wiperToLow) else $error("shutdown outputs differ");
endmodule
`default_nettype wire

// >>> tb/spi_host_model.sv
// Behavioural SPI host in mode 0 driving select, clock and data in.
// Assumes a pulled-up return pin and calls made just after an mclk edge.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input  wire logic mclk,
    output var  logic csN,
    output var  logic sck,
    output var  logic sdi,
    input  wire logic sdoPin
);
    import dcp_pkg::*;
    initial
    begin
        csN = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Clock stands low between frames; lead stretches the select setup
    task automatic frame(input byte_t id, input byte_t ins, input int n, input int lead,
                         input byte_t wd[8], output byte_t rd[8]);
        byte_t tx;
        byte_t rx;
        csN <= 1'b0;
        repeat (4 + lead) @(posedge mclk);
        for (int k = -2; k < n; k++)
        begin
            tx = (k == -2) ? id : ((k == -1) ? ins : wd[k]);
            for (int i = 7; i >= 0; i--)
            begin
                sdi <= tx[i];
                repeat (4) @(posedge mclk);
                sck <= 1'b1;
                // Sampled late in the high phase: output lags the fall by 4 mclk
                repeat (4) @(posedge mclk);
                rx[i] = sdoPin;
                sck <= 1'b0;
            end
            if (k >= 0)
                rd[k] = rx;
        end
        repeat (4) @(posedge mclk);
        csN <= 1'b1;
        sdi <= ~sdi;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/test_spi_dual_wiper_register_control.sv
// Self-checking bench for the dual wiper control block with a host model.
// Assumes the monitor bound below and a pull-up on the data return pin.
`timescale 1ns/1ns
`default_nettype none
module test_spi_dual_wiper_register_control;
    import dcp_pkg::*;
    localparam int NvCycles = 800;
    logic   mclk;
    logic   nrst;
    logic   csN;
    logic   sck;
    logic   sdi;
    logic   shutdownPinN;
    wiper_t wiper0;
    wiper_t wiper1;
    logic   highTermOpen;
    logic   wiperToLow;
    logic   sdoOut;
    logic   sdoOeN;
    logic   nvWriteBusy;
    wire logic sdoPin = sdoOeN ? 1'b1 : sdoOut;
    int     errors = 0;
    int     n_compared = 0;
    int     cycles = 0;
    integer seed = 32'hd0149bba;
    byte_t  wd[8];
    byte_t  rd[8];
    dcp_spi_ctrl #(.NV_WRITE_CYCLES(NvCycles), .RECALL_CYCLES(4)) dut (.mclk(mclk),
        .nrst(nrst), .csN(csN), .sck(sck), .sdi(sdi), .shutdownPinN(shutdownPinN),
        .wiper0(wiper0), .wiper1(wiper1), .highTermOpen(highTermOpen),
        .wiperToLow(wiperToLow), .sdoOut(sdoOut), .sdoOeN(sdoOeN), .nvWriteBusy(nvWriteBusy));
    spi_host_model host (.mclk(mclk), .csN(csN), .sck(sck), .sdi(sdi), .sdoPin(sdoPin));
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk_byte(input byte_t got, input byte_t exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s got %b", $time, what, got);
        end
    endtask
    function automatic byte_t ctl_val(input logic volSel, input logic shutBit, input logic busyBit);
        return {volSel, shutBit, busyBit, 5'h00};
    endfunction
    function automatic byte_t as_wiper(input byte_t d);
        return {1'b0, d[6:0]};
    endfunction
    task automatic wr(input logic [3:0] a, input int n);
        host.frame(8'ha0, {4'hc, a}, n, 0, wd, rd);
    endtask
    task automatic rdn(input logic [3:0] a, input int n, input int lead);
        host.frame(8'ha0, {4'hb, a}, n, lead, wd, rd);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < NvCycles + 100 && nvWriteBusy !== 1'b0; i++)
            @(posedge mclk);
        chk_bit(nvWriteBusy, 1'b0, "nv write end");
    endtask
    initial
    begin
        byte_t v;
        byte_t g;
        wiper_t keep;
        nrst = 1'b0;
        shutdownPinN = 1'b1;
        wd = '{default: 8'h00};
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (30) @(posedge mclk);
        chk_byte({1'b0, wiper0}, 8'h40, "wiper0 reset");
        chk_byte({1'b0, wiper1}, 8'h40, "wiper1 reset");
        rdn(4'h8, 1, 3);
        chk_byte(rd[0], ctl_val(1'b0, 1'b1, 1'b0), "ctl reset");
        v = 8'($random(seed));
        wd[0] = v;
        wr(4'h1, 1);
        chk_byte({1'b0, wiper1}, as_wiper(v), "wiper via initial");
        chk_bit(nvWriteBusy, 1'b1, "nv write start");
        rdn(4'h8, 1, 0);
        chk_byte(rd[0], ctl_val(1'b0, 1'b1, 1'b1), "busy flag");
        wd[0] = 8'h8f;
        wr(4'h8, 1);
        wd[0] = ~v;
        wr(4'h1, 1);
        chk_byte({1'b0, wiper1}, as_wiper(v), "wiper locked");
        wait_idle();
        rdn(4'h8, 1, 0);
        chk_byte(rd[0], ctl_val(1'b0, 1'b1, 1'b0), "ctl locked");
        rdn(4'h0, 2, 0);
        chk_byte(rd[0], 8'h40, "initial0");
        chk_byte(rd[1], v, "initial1");
        wd[0] = ctl_val(1'b1, 1'b1, 1'b0);
        wr(4'h8, 1);
        for (int i = 0; i < 4; i++)
        begin
            v = (i < 2) ? {1'b0, {7{i[0]}}} : 8'($random(seed));
            wd[0] = v;
            wr({3'h0, i[0]}, 1);
            chk_byte(i[0] ? {1'b0, wiper1} : {1'b0, wiper0}, as_wiper(v), "wiper write");
        end
        g = 8'($random(seed));
        v = 8'($random(seed));
        wd[0] = g;
        wd[1] = v;
        wr(4'h6, 2);
        chk_byte({1'b0, wiper0}, as_wiper(v), "write wrap");
        wait_idle();
        rdn(4'h6, 2, 5);
        chk_byte(rd[0], g, "general 6");
        chk_byte(rd[1], as_wiper(v), "read wrap");
        wd[0] = 8'h5a;
        wr(4'h7, 1);
        rdn(4'h7, 2, 0);
        chk_byte(rd[0], 8'h00, "reserved");
        chk_byte(rd[1], ctl_val(1'b1, 1'b1, 1'b0), "after reserved");
        keep = wiper0;
        shutdownPinN <= 1'b0;
        repeat (6) @(posedge mclk);
        chk_bit(highTermOpen, 1'b1, "pin shutdown");
        chk_bit(wiperToLow, 1'b1, "pin wiper low");
        rdn(4'h8, 1, 0);
        chk_byte(rd[0], ctl_val(1'b1, 1'b1, 1'b0), "read in shutdown");
        shutdownPinN <= 1'b1;
        repeat (6) @(posedge mclk);
        chk_bit(highTermOpen, 1'b0, "pin resume");
        wd[0] = ctl_val(1'b1, 1'b0, 1'b0);
        wr(4'h8, 1);
        chk_bit(wiperToLow, 1'b1, "bit shutdown");
        wd[0] = ctl_val(1'b1, 1'b1, 1'b0);
        wr(4'h8, 1);
        chk_bit(highTermOpen, 1'b0, "bit resume");
        chk_byte({1'b0, wiper0}, {1'b0, keep}, "wiper kept");
        for (int c = 0; c < 18; c++)
        begin
            wd[0] = 8'h00;
            if (c == 11 || c == 12)
                continue;
            if (c < 16)
                host.frame(8'ha0, {c[3:0], 4'h8}, 2, 0, wd, rd);
            else
                host.frame((c == 16) ? 8'ha1 : 8'h30, {4'hb, 4'h8}, 2, 0, wd, rd);
            chk_byte(rd[0] & rd[1], 8'hff, "ignored frame");
        end
        rdn(4'h8, 1, 0);
        chk_byte(rd[0], ctl_val(1'b1, 1'b1, 1'b0), "ctl after ignored");
        chk_bit(sdoOeN, 1'b1, "released idle");
        // Second reset in mid-run: wipers and control bits must come back to their start values
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (30) @(posedge mclk);
        chk_byte({1'b0, wiper0}, 8'h40, "wiper0 second reset");
        chk_byte({1'b0, wiper1}, 8'h40, "wiper1 second reset");
        rdn(4'h8, 1, 0);
        chk_byte(rd[0], ctl_val(1'b0, 1'b1, 1'b0), "ctl second reset");
        tally_and_finish();
    end
endmodule
bind dcp_spi_ctrl wiper_ctrl_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES),
    .RECALL_CYCLES(RECALL_CYCLES)) mon (.mclk(mclk), .nrst(nrst), .csN(csN),
    .shutdownPinN(shutdownPinN), .wiper0(wiper0), .wiper1(wiper1),
    .highTermOpen(highTermOpen), .wiperToLow(wiperToLow), .sdoOut(sdoOut),
    .sdoOeN(sdoOeN), .nvWriteBusy(nvWriteBusy));
`default_nettype wire
